/* shared/aof_pkg.sv */
// package: constants, types and helpers for the converter output formatter
// Summary of operation
// - stabilizer: rising edge only, own midpoint falling edge
// - stabilizer relocks on the 101st rise once stopped
// - output strap picks one of four output modes
// - format strap picks format and stabilizer
// - range flag marks over/under range per bus
// - forwarded clock is delayed copy of sample clock
// - bus A changes as clock A (single-ended) or fwd_clock (differential) falls, B rises
// - demux: clocks at half rate, bus B with A
// - full-rate: bus A only, bus B inactive
// - scramble: XOR LSB into every upper bit
// - dither value added, then subtracted from result
// - each result is a 16-bit word
`default_nettype none
package aof_pkg;
	localparam int          SAMPLE_W      = 16;
	localparam int          DITHER_W      = 8;
	localparam int          LFSR_W        = 32;
	localparam logic [31:0] LFSR_TAPS     = 32'h80200003;
	localparam logic [31:0] LFSR_SEED     = 32'h00000001;
	localparam int          PCLK_MHZ      = 100;
	localparam int          STOP_NS       = 2000;
	localparam int          CNT_W         = 9;
	localparam logic [8:0]  STOP_CYCLES   = 9'((STOP_NS * PCLK_MHZ + 999) / 1000);
	localparam int          LOCK_W        = 7;
	localparam logic [6:0]  LOCK_CYCLES   = 7'h64;
	localparam logic [1:0]  STRAP_SETTLE  = 2'h3;
	localparam int          PIN_W         = 24;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0]  ADDR_RESULT   = 8'h10;
	localparam int          CTRL_DITHER   = 0;
	localparam int          CTRL_OUT_EN   = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h2;
	localparam int          STAT_MODE_LSB = 0;
	localparam int          STAT_FMT      = 2;
	localparam int          STAT_STAB     = 3;
	localparam int          STAT_LOCK     = 4;
	localparam int          STAT_SCR      = 5;
	localparam int          RES_FLAG      = 16;
	localparam int          IRQ_W         = 3;
	localparam int          IRQ_RANGE     = 0;
	localparam int          IRQ_LOCK_LOST = 1;
	localparam int          IRQ_LOCK_GAIN = 2;

	// strap codes 0..3 stand for ground, 1/3, 2/3 and full supply
	typedef enum logic [1:0] {AOF_FULL_RATE, AOF_DEMUX, AOF_LP_DIFF, AOF_STD_DIFF} aof_out_mode_t;
	typedef enum logic {AOF_OFFSET_BIN, AOF_TWOS_COMP} aof_format_t;

	function automatic aof_format_t aof_format_of(input logic [1:0] strap);
		return strap[1] ? AOF_TWOS_COMP : AOF_OFFSET_BIN;
	endfunction

	function automatic logic aof_stab_of(input logic [1:0] strap);
		return strap[1] ^ strap[0];
	endfunction

	function automatic logic aof_single_ended(input aof_out_mode_t mode);
		return (mode == AOF_FULL_RATE) || (mode == AOF_DEMUX);
	endfunction
endpackage
`default_nettype wire

/* shared/aof_stab_if.sv */
// interface: edge events between the core and the duty cycle stabilizer
`timescale 1ns/100ps
`default_nettype none
interface aof_stab_if;
	logic enable;
	logic in_rise;
	logic in_fall;
	logic int_rise;
	logic int_fall;
	logic locked;
	modport stab (input enable, input in_rise, input in_fall, output int_rise, output int_fall, output locked);
	modport core (output enable, output in_rise, output in_fall, input int_rise, input int_fall, input locked);
endinterface
`default_nettype wire

/* core/aof_duty_stab.sv */
// module: duty cycle stabilizer and lock tracking for the sample clock
`timescale 1ns/100ps
`default_nettype none
module aof_duty_stab (
	// clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// edge events
	aof_stab_if.stab    sif
);
	import aof_pkg::*;

	logic [CNT_W-1:0]  since_rise;
	logic [CNT_W-1:0]  half_period;
	logic [LOCK_W-1:0] lock_count;
	logic              stopped;
	logic              timing_ok;

	assign stopped   = (since_rise == STOP_CYCLES);
	assign timing_ok = sif.locked || !sif.enable;

	// measure the input period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_rise  <= '0;
			half_period <= '0;
		end else if (sif.in_rise) begin
			since_rise  <= '0;
			half_period <= stopped ? '0 : CNT_W'((since_rise + 1'b1) >> 1);
		end else if (!stopped) begin
			since_rise <= since_rise + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_count <= '0;
			sif.locked <= 1'b0;
		end else if (stopped) begin
			lock_count <= '0;
			sif.locked <= 1'b0;
		end else if (sif.in_rise && !sif.locked) begin
			lock_count <= lock_count + 1'b1;
			sif.locked <= (lock_count == LOCK_CYCLES - 1'b1);
		end
	end

	// rising edge kept, falling edge made at midpoint
	assign sif.int_rise = sif.in_rise && timing_ok;
	assign sif.int_fall = timing_ok && (sif.enable ? (half_period != '0 && since_rise == half_period && !sif.in_rise)
		: sif.in_fall);
endmodule
`default_nettype wire

/* core/aof_top.sv */
// module: converter digital back end with output formatting and APB registers
`timescale 1ns/100ps
`default_nettype none
module aof_top (
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic [aof_pkg::ADDR_W-1:0] paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// sample clock, straps and converter core pins
	input  wire logic                    sample_clock_in,
	input  wire logic [1:0]              output_mode_strap,
	input  wire logic [1:0]              format_strap,
	input  wire logic                    scramble_enable,
	input  wire logic [aof_pkg::SAMPLE_W-1:0] raw_sample,
	input  wire logic                    raw_over_range,
	input  wire logic                    raw_under_range,
	// dither source
	output logic [aof_pkg::DITHER_W-1:0] dither_value,
	// output buses and clocks
	output logic [aof_pkg::SAMPLE_W-1:0] data_a,
	output logic [aof_pkg::SAMPLE_W-1:0] data_b,
	output logic                         range_flag_a,
	output logic                         range_flag_b,
	output logic                         fwd_clock_a,
	output logic                         fwd_clock_b,
	output logic                         fwd_clock,
	output logic                         range_flag,
	// interrupt
	output logic                         irq
);
	import aof_pkg::*;

	logic [PIN_W-1:0]    pin_s1;
	logic [PIN_W-1:0]    pin_s2;
	logic                clk_prev;
	logic                clk_s;
	logic                scr_s;
	logic                over_s;
	logic                under_s;
	logic [SAMPLE_W-1:0] sample_s;
	logic [1:0]          mode_strap_s;
	logic [1:0]          fmt_strap_s;
	logic [1:0]          settle;
	logic                straps_taken;
	aof_out_mode_t       mode;
	aof_format_t         fmt;
	logic                stab_on;
	logic [1:0]          ctrl;
	logic [IRQ_W-1:0]    irq_status;
	logic [IRQ_W-1:0]    irq_mask;
	logic [IRQ_W-1:0]    next_irq_status;
	logic [IRQ_W-1:0]    events;
	logic                locked_prev;
	logic [LFSR_W-1:0]   lfsr;
	logic [SAMPLE_W-1:0] word;
	logic                word_flag;
	logic [SAMPLE_W-1:0] hold_word;
	logic                hold_flag;
	logic                demux_phase;
	logic [SAMPLE_W-1:0] last_result;
	logic                last_flag;
	logic                se;
	logic                rise_go;
	logic                fall_go;
	logic                apb_take;
	logic                apb_done;
	logic                mapped;

	aof_stab_if stab_bus ();

	aof_duty_stab u_stab (
		.pclk    (pclk),
		.presetn (presetn),
		.sif     (stab_bus.stab)
	);

	// subtract dither, convert format, then scramble
	function automatic logic [SAMPLE_W-1:0] aof_shape(input logic [SAMPLE_W-1:0] raw,
		input logic [DITHER_W-1:0] dith, input aof_format_t f, input logic scr);
		logic [SAMPLE_W-1:0] v;
		v = raw - {{(SAMPLE_W-DITHER_W){1'b0}}, dith};
		if (f == AOF_TWOS_COMP) begin
			v[SAMPLE_W-1] = ~v[SAMPLE_W-1];
		end
		if (scr) begin
			v[SAMPLE_W-1:1] = v[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){v[0]}};
		end
		return v;
	endfunction

	// two-stage synchroniser for every pin input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1   <= '0;
			pin_s2   <= '0;
			clk_prev <= 1'b0;
		end else begin
			pin_s1   <= {sample_clock_in, scramble_enable, raw_over_range, raw_under_range, raw_sample,
				output_mode_strap, format_strap};
			pin_s2   <= pin_s1;
			clk_prev <= pin_s2[PIN_W-1];
		end
	end

	assign clk_s        = pin_s2[PIN_W-1];
	assign scr_s        = pin_s2[PIN_W-2];
	assign over_s       = pin_s2[PIN_W-3];
	assign under_s      = pin_s2[PIN_W-4];
	assign sample_s     = pin_s2[SAMPLE_W+3:4];
	assign mode_strap_s = pin_s2[3:2];
	assign fmt_strap_s  = pin_s2[1:0];

	// straps caught once the synchroniser has settled after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle       <= '0;
			straps_taken <= 1'b0;
			mode         <= AOF_FULL_RATE;
			fmt          <= AOF_OFFSET_BIN;
			stab_on      <= 1'b0;
		end else if (!straps_taken) begin
			settle <= settle + 1'b1;
			if (settle == STRAP_SETTLE) begin
				straps_taken <= 1'b1;
				mode         <= aof_out_mode_t'(mode_strap_s);
				fmt          <= aof_format_of(fmt_strap_s);
				stab_on      <= aof_stab_of(fmt_strap_s);
			end
		end
	end

	assign stab_bus.enable  = stab_on;
	assign stab_bus.in_rise = clk_s && !clk_prev && straps_taken;
	assign stab_bus.in_fall = !clk_s && clk_prev && straps_taken;
	assign rise_go          = stab_bus.int_rise && ctrl[CTRL_OUT_EN];
	assign fall_go          = stab_bus.int_fall && ctrl[CTRL_OUT_EN];
	assign se               = aof_single_ended(mode);

	assign word      = aof_shape(sample_s, dither_value, fmt, scr_s);
	assign word_flag = over_s || under_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr         <= LFSR_SEED;
			dither_value <= '0;
		end else if (rise_go) begin
			lfsr         <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
			dither_value <= ctrl[CTRL_DITHER] ? lfsr[DITHER_W-1:0] : '0;
		end
	end

	// output buses and forwarded clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_word    <= '0;
			hold_flag    <= 1'b0;
			demux_phase  <= 1'b0;
			data_a       <= '0;
			data_b       <= '0;
			range_flag_a <= 1'b0;
			range_flag_b <= 1'b0;
			range_flag   <= 1'b0;
			fwd_clock_a  <= 1'b0;
			fwd_clock_b  <= 1'b0;
			fwd_clock    <= 1'b0;
		end else if (mode == AOF_DEMUX) begin
			// half-rate clocks, bus B with bus A
			if (rise_go) begin
				demux_phase <= !demux_phase;
				fwd_clock_a <= !demux_phase;
				fwd_clock_b <= demux_phase;
				if (!demux_phase) begin
					hold_word <= word;
					hold_flag <= word_flag;
				end else begin
					// alternate samples on A then B
					data_a       <= hold_word;
					range_flag_a <= hold_flag;
					data_b       <= word;
					range_flag_b <= word_flag;
				end
			end
		end else begin
			data_b       <= '0;
			range_flag_b <= 1'b0;
			demux_phase  <= 1'b0;
			if (rise_go) begin
				hold_word <= word;
				hold_flag <= word_flag;
				fwd_clock_a <= se;
				fwd_clock_b <= 1'b0;
				fwd_clock   <= !se;
			end else if (fall_go) begin
				// bus A changes as clock A (single-ended) or fwd_clock (differential) falls
				data_a       <= hold_word;
				range_flag_a <= se && hold_flag;
				range_flag   <= !se && hold_flag;
				fwd_clock_a  <= 1'b0;
				fwd_clock_b  <= se;
				fwd_clock    <= 1'b0;
			end
		end
	end

	// last result for software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_result <= '0;
			last_flag   <= 1'b0;
			locked_prev <= 1'b0;
		end else begin
			locked_prev <= stab_bus.locked;
			if (rise_go) begin
				last_result <= word;
				last_flag   <= word_flag;
			end
		end
	end

	assign events[IRQ_RANGE]     = rise_go && word_flag;
	assign events[IRQ_LOCK_LOST] = locked_prev && !stab_bus.locked;
	assign events[IRQ_LOCK_GAIN] = !locked_prev && stab_bus.locked;

	// apb handshake: one wait cycle, answer in second access cycle
	assign apb_take = psel && penable && !pready;
	assign apb_done = psel && penable && pready;
	assign mapped   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT)
		|| (paddr == ADDR_IRQ_MASK) || (paddr == ADDR_RESULT);

	// sticky status: set wins over write-one clear
	always_comb begin
		next_irq_status = irq_status;
		if (apb_done && pwrite && paddr == ADDR_IRQ_STAT) begin
			next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
		end
		next_irq_status = next_irq_status | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= CTRL_RESET;
			irq_mask <= '0;
		end else if (apb_done && pwrite) begin
			if (paddr == ADDR_CTRL) begin
				ctrl <= pwdata[1:0];
			end
			if (paddr == ADDR_IRQ_MASK) begin
				irq_mask <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// register reads and answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apb_take;
			pslverr <= apb_take && !mapped;
			prdata  <= '0;
			if (apb_take && !pwrite) begin
				unique case (paddr)
					ADDR_CTRL: begin
						prdata[1:0] <= ctrl;
					end
					ADDR_STATUS: begin
						prdata[STAT_MODE_LSB+1:STAT_MODE_LSB] <= mode;
						prdata[STAT_FMT]  <= fmt;
						prdata[STAT_STAB] <= stab_on;
						prdata[STAT_LOCK] <= stab_bus.locked;
						prdata[STAT_SCR]  <= scr_s;
					end
					ADDR_IRQ_STAT: begin
						prdata[IRQ_W-1:0] <= irq_status;
					end
					ADDR_IRQ_MASK: begin
						prdata[IRQ_W-1:0] <= irq_mask;
					end
					ADDR_RESULT: begin
						prdata[SAMPLE_W-1:0] <= last_result;
						prdata[RES_FLAG]     <= last_flag;
					end
					default: begin
						prdata <= '0;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* sim/aof_checker.sv */
// checker: port-level timing of buses, flags and forwarded clocks
`timescale 1ns/100ps
`default_nettype none
module aof_checker (
	// clock and reset
	input wire logic                          pclk,
	input wire logic                          presetn,
	// strap and sample clock
	input wire logic [1:0]                    output_mode_strap,
	input wire logic                          sample_clock_in,
	// outputs under watch
	input wire logic [aof_pkg::SAMPLE_W-1:0]  data_a,
	input wire logic [aof_pkg::SAMPLE_W-1:0]  data_b,
	input wire logic                          range_flag_a,
	input wire logic                          fwd_clock_a,
	input wire logic                          fwd_clock_b,
	input wire logic                          fwd_clock,
	input wire logic                          irq,
	input wire logic                          pslverr
);
	import aof_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pair_exclusive: assert property (!(fwd_clock_a && fwd_clock_b))
		else $error("clock a and clock b high together");
	a_diff_se_quiet: assert property (output_mode_strap[1] |-> !fwd_clock_a && !fwd_clock_b)
		else $error("single-ended clocks run in differential mode");
	a_se_diff_quiet: assert property (!output_mode_strap[1] |-> !fwd_clock)
		else $error("differential clock runs in single-ended mode");
	a_bus_a_fall: assert property (!output_mode_strap[1] && $changed(data_a) |-> $fell(fwd_clock_a))
		else $error("bus a changed away from clock a fall");
	a_bus_b_fall: assert property (output_mode_strap == 2'h1 && $changed(data_b) |-> $fell(fwd_clock_a))
		else $error("bus b changed away from clock a fall");
	a_bus_b_idle: assert property (output_mode_strap == 2'h0 |-> $stable(data_b))
		else $error("bus b active in full-rate mode");
	a_flag_with_data: assert property (!output_mode_strap[1] && $changed(range_flag_a) |-> $fell(fwd_clock_a))
		else $error("range flag a moved apart from its data");
	a_fwd_follows: assert property (output_mode_strap == 2'h0 && $rose(fwd_clock_a) |-> $past(sample_clock_in, 2))
		else $error("forwarded clock rose without a sample clock high");
	a_demux_half: assert property (output_mode_strap == 2'h1 && $rose(fwd_clock_a) |-> fwd_clock_a [*6])
		else $error("demux clock a high for less than a sample period");
	c_demux: cover property (output_mode_strap == 2'h1 && $rose(fwd_clock_a));
	c_diff: cover property ($rose(fwd_clock));
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (pslverr);
endmodule
bind aof_top aof_checker u_aof_checker (.pclk, .presetn, .output_mode_strap, .sample_clock_in, .data_a, .data_b,
	.range_flag_a, .fwd_clock_a, .fwd_clock_b, .fwd_clock, .irq, .pslverr);
`default_nettype wire

/* sim/aof_capture_model.sv */
// model: downstream capture logic that latches and descrambles the buses
`timescale 1ns/100ps
`default_nettype none
module aof_capture_model (
	// capture clocks
	input wire logic                          fwd_clock_a,
	input wire logic                          fwd_clock,
	// received buses
	input wire logic [aof_pkg::SAMPLE_W-1:0]  data_a,
	input wire logic [aof_pkg::SAMPLE_W-1:0]  data_b,
	input wire logic                          scramble_enable,
	// recovered words
	output logic [aof_pkg::SAMPLE_W-1:0]      word_a,
	output logic [aof_pkg::SAMPLE_W-1:0]      word_b
);
	import aof_pkg::*;
	wire logic cap_clk;
	assign cap_clk = fwd_clock_a | fwd_clock;
	always @(posedge cap_clk) begin
		word_a <= scramble_enable ? data_a ^ {{(SAMPLE_W-1){data_a[0]}}, 1'b0} : data_a;
		word_b <= scramble_enable ? data_b ^ {{(SAMPLE_W-1){data_b[0]}}, 1'b0} : data_b;
	end
endmodule
`default_nettype wire

/* sim/adc_output_formatter_tb.sv */
// testbench: output modes, formats, demux pairing, range flags and interrupt
`timescale 1ns/100ps
`default_nettype none
module adc_output_formatter_tb;
	import aof_pkg::*;
	logic                pclk = 0;
	logic                presetn = 0;
	logic [ADDR_W-1:0]   paddr = 0;
	logic                psel = 0;
	logic                penable = 0;
	logic                pwrite = 0;
	logic [31:0]         pwdata = 0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                sample_clock_in = 0;
	logic [1:0]          output_mode_strap = 0;
	logic [1:0]          format_strap = 0;
	logic                scramble_enable = 0;
	logic [SAMPLE_W-1:0] raw_sample = 0;
	logic                raw_over_range = 0;
	logic                raw_under_range = 0;
	logic [DITHER_W-1:0] dither_value;
	logic [SAMPLE_W-1:0] data_a, data_b, word_a, word_b;
	logic                range_flag_a, range_flag_b, fwd_clock_a, fwd_clock_b, fwd_clock, range_flag, irq;
	logic                sc_run = 0;
	int                  hi_ns = 40;
	logic [31:0]         rd;
	logic                err;
	int                  fail_count = 0;
	int                  compares = 0;
	always #5 pclk = ~pclk;
	always begin
		wait (sc_run);
		#3 sample_clock_in = 1;
		#(hi_ns) sample_clock_in = 0;
		#(77 - hi_ns);
	end
	aof_top u_aof_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.sample_clock_in, .output_mode_strap, .format_strap, .scramble_enable, .raw_sample, .raw_over_range,
		.raw_under_range, .dither_value, .data_a, .data_b, .range_flag_a, .range_flag_b, .fwd_clock_a,
		.fwd_clock_b, .fwd_clock, .range_flag, .irq);
	aof_capture_model u_aof_capture_model (.fwd_clock_a, .fwd_clock, .data_a, .data_b, .scramble_enable,
		.word_a, .word_b);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic restart(input logic [1:0] m, input logic [1:0] f);
		@(posedge pclk);
		presetn <= 0;
		output_mode_strap <= m;
		format_strap <= f;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		repeat (8) @(posedge pclk);
	endtask
	task automatic run(input logic [SAMPLE_W-1:0] v0, input logic [SAMPLE_W-1:0] v1, input int n);
		raw_sample <= v0;
		sc_run <= 1;
		for (int i = 1; i < n; i++) begin
			@(negedge sample_clock_in);
			raw_sample <= i[0] ? v1 : v0;
		end
		@(negedge sample_clock_in);
		sc_run <= 0;
		repeat (8) @(posedge pclk);
	endtask
	task automatic s_modes();
		for (int m = 0; m < 4; m++) begin
			restart(m[1:0], 2'h0);
			raw_over_range <= m[0];
			run(16'h4321, 16'h4321, 4);
			apb(1'b0, ADDR_STATUS, 32'h0);
			check(rd[1:0], m[1:0]);
			check(data_a, 16'h4321);
			check(dither_value, 8'h0);
			check(m[1] ? range_flag : range_flag_a, m[0]);
			if (m == 0) check(data_b, 16'h0);
			if (m == 1) check(range_flag_b, 1'b1);
		end
		raw_over_range <= 0;
	endtask
	task automatic s_formats();
		logic [SAMPLE_W-1:0] e;
		for (int f = 0; f < 4; f++) begin
			restart(2'h0, f[1:0]);
			scramble_enable <= f[0];
			hi_ns = f == 1 ? 24 : f == 2 ? 56 : 40;
			if (f == 1 || f == 2) begin
				run(16'h8005, 16'h8005, 50);
				check(data_a, 16'h0);
			end
			run(16'h8005, 16'h8005, 60);
			e = f[1] ? 16'h0005 : 16'h8005;
			check(word_a, e);
			e = f[0] ? e ^ {{(SAMPLE_W-1){e[0]}}, 1'b0} : e;
			check(data_a, e);
			apb(1'b0, ADDR_STATUS, 32'h0);
			check(rd[5:2], {f[0], (f == 1 || f == 2), (f == 1 || f == 2), f[1]});
		end
		scramble_enable <= 0;
		hi_ns = 40;
	endtask
	task automatic s_demux();
		restart(2'h1, 2'h0);
		run(16'h1111, 16'h2222, 6);
		check({data_a, data_b}, 32'h11112222);
		check({word_a, word_b}, 32'h11112222);
	endtask
	task automatic s_dither();
		logic [DITHER_W-1:0] d;
		restart(2'h0, 2'h0);
		apb(1'b1, ADDR_CTRL, 32'h3);
		raw_sample <= 16'h1234;
		sc_run <= 1;
		repeat (5) @(negedge sample_clock_in);
		d = dither_value;
		@(negedge sample_clock_in);
		sc_run <= 0;
		repeat (8) @(posedge pclk);
		check(d != 8'h0, 1'b1);
		check(data_a, 16'h1234 - {8'h0, d});
		apb(1'b0, ADDR_RESULT, 32'h0);
		check(rd, {16'h0, 16'h1234 - {8'h0, d}});
	endtask
	task automatic s_irq();
		restart(2'h0, 2'h0);
		apb(1'b0, 8'h40, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		raw_under_range <= 1;
		run(16'h0, 16'h0, 3);
		raw_under_range <= 0;
		check(range_flag_a, 1'b1);
		check(irq, 1'b0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h1);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check(rd[0], 1'b1);
		check(irq, 1'b1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h1);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check(rd[0], 1'b0);
		check(irq, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		s_modes();
		s_formats();
		s_demux();
		s_dither();
		s_irq();
		report_and_stop();
	end
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
